// ### gdr_gate_logic.sv
/*
  Gate drive logic of a three-phase half-bridge driver: command decode,
  shoot-through block, enable gating, supply protection with hysteresis,
  thermal shutdown without hysteresis, re-arm on the next falling command edge, open-drain fault
  pin and a classic Wishbone register slave.
  Assumes synchronous command, enable and measurement inputs, and that
  the pin pads hold pull-ups on the commands and a pull-down on enable.
*/
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module gdr_gate_logic
  import gdr_pkg::*;
#(
  parameter int EN_FILT_CYC = GDR_EN_FILT_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [GDR_ADR_W-1:0] wbAdr,
  input wire logic [31:0] wbDatW,
  input wire logic [3:0] wbSel,
  output logic [31:0] wbDatR,
  output logic wbAck,
  input wire logic [GDR_PHASES-1:0] highSideCmdN,
  input wire logic [GDR_PHASES-1:0] lowSideCmdN,
  input wire logic enableIn,
  input wire logic [GDR_MV_W-1:0] mainSupplyMv,
  input wire logic [GDR_MV_W-1:0] logicSupplyMv,
  input wire logic [GDR_PHASES-1:0][GDR_MV_W-1:0] gateDriveSupplyMv,
  input wire logic thermalShutdown,
  output logic [GDR_PHASES-1:0] highGateOut,
  output logic [GDR_PHASES-1:0] lowGateOut,
  input wire logic faultOutNIn,
  output logic faultOutNOut,
  output logic faultOutNOe,
  output logic pumpBoostEn
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  gdr_prot_t flags_r;
  gdr_prot_t flags_nxt;
  logic enFilt;
  logic softOff_r;
  logic hardGate;
  logic [GDR_PHASES-1:0] highPrev_r;
  logic [GDR_PHASES-1:0] lowPrev_r;
  logic [GDR_PHASES-1:0] fallEdge;
  logic [GDR_PHASES-1:0] rearm_r;
  logic [GDR_PHASES-1:0] high_r;
  logic [GDR_PHASES-1:0] low_r;
  logic [GDR_PHASES-1:0] high_nxt;
  logic [GDR_PHASES-1:0] low_nxt;
  logic faultOe_r;
  logic pump_r;
  logic ack_r;
  logic [31:0] datR_r;
  logic wbReq;
  logic [31:0] statWord;

  // Hysteresis comparator; setHigh selects an over- or under-threshold flag
  function automatic logic hyst(
    input logic cur,
    input logic [GDR_MV_W-1:0] v,
    input logic [GDR_MV_W-1:0] setLvl,
    input logic [GDR_MV_W-1:0] clrLvl,
    input logic setHigh
  );
    logic res;
    res = cur;
    if (setHigh) begin
      if (v >= setLvl) begin
        res = 1'b1;
      end else if (v <= clrLvl) begin
        res = 1'b0;
      end
    end else begin
      if (v <= setLvl) begin
        res = 1'b1;
      end else if (v >= clrLvl) begin
        res = 1'b0;
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Enable filter

  gdr_enable_filter #(
    .CYCLES(EN_FILT_CYC)
  ) u_gdr_enable_filter (
    .clock(clock),
    .rst(rst),
    .rawIn(enableIn),
    .filtOut(enFilt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Protection flags

  always_comb begin
    flags_nxt = flags_r;
    flags_nxt.overV = hyst(flags_r.overV, mainSupplyMv, GDR_OVP_SET_MV, GDR_OVP_CLR_MV, 1'b1);
    flags_nxt.mainUv = hyst(flags_r.mainUv, mainSupplyMv, GDR_MUV_SET_MV, GDR_MUV_CLR_MV, 1'b0);
    flags_nxt.logicUv = hyst(flags_r.logicUv, logicSupplyMv, GDR_LUV_SET_MV, GDR_LUV_CLR_MV, 1'b0);
    for (int p = 0; p < GDR_PHASES; p++) begin
      flags_nxt.gateUv[p] = hyst(flags_r.gateUv[p], gateDriveSupplyMv[p], GDR_GUV_SET_MV, GDR_GUV_CLR_MV,
                                 1'b0);
    end
    flags_nxt.thermal = thermalShutdown;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flags_r <= GDR_PROT_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Boost stops under main undervoltage; the oscillator is not gated here
  always_ff @(posedge clock) begin
    if (rst) begin
      pump_r <= 1'b0;
    end else begin
      pump_r <= ~flags_r.mainUv;
    end
  end

  assign pumpBoostEn = pump_r;

  ////////////////////////////////////////////////////////////////////////////
  // Gating and re-arm

  // Gate-supply undervoltage is deliberately absent: it only flags a fault
  assign hardGate = flags_r.overV | flags_r.mainUv | flags_r.logicUv | flags_r.thermal
                  | ~enFilt | softOff_r;

  assign fallEdge = (highPrev_r & ~highSideCmdN) | (lowPrev_r & ~lowSideCmdN);

  always_ff @(posedge clock) begin
    if (rst) begin
      highPrev_r <= '1;
      lowPrev_r <= '1;
    end else begin
      highPrev_r <= highSideCmdN;
      lowPrev_r <= lowSideCmdN;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rearm_r <= '1;
    end else if (hardGate) begin
      rearm_r <= '1;
    end else begin
      rearm_r <= rearm_r & ~fallEdge;
    end
  end

  // No filtering: a command change reaches the gate one clock later
  always_comb begin
    for (int p = 0; p < GDR_PHASES; p++) begin
      high_nxt[p] = ~highSideCmdN[p] & lowSideCmdN[p];
      low_nxt[p] = ~lowSideCmdN[p] & highSideCmdN[p];
      if (hardGate || (rearm_r[p] && !fallEdge[p])) begin
        high_nxt[p] = 1'b0;
        low_nxt[p] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      high_r <= '0;
      low_r <= '0;
    end else begin
      high_r <= high_nxt;
      low_r <= low_nxt;
    end
  end

  assign highGateOut = high_r;
  assign lowGateOut = low_r;

  ////////////////////////////////////////////////////////////////////////////
  // Open-drain fault pin

  always_ff @(posedge clock) begin
    if (rst) begin
      faultOe_r <= 1'b0;
    end else begin
      faultOe_r <= |flags_r;
    end
  end

  assign faultOutNOut = 1'b0;
  assign faultOutNOe = faultOe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request, writes land on the edge that samples the ack, unmapped reads zero

  assign wbReq = wbCyc & wbStb & ~ack_r;

  always_comb begin
    statWord = '0;
    statWord[GDR_ST_FLAGS_LSB +: $bits(gdr_prot_t)] = flags_r;
    statWord[GDR_ST_EN_BIT] = enFilt;
    statWord[GDR_ST_PIN_BIT] = faultOutNIn;
    statWord[GDR_ST_REARM_LSB +: GDR_PHASES] = rearm_r;
    statWord[GDR_ST_HIGH_LSB +: GDR_PHASES] = high_r;
    statWord[GDR_ST_LOW_LSB +: GDR_PHASES] = low_r;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wbReq;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      softOff_r <= GDR_CTRL_OFF_RST;
    end else if (wbCyc && wbStb && ack_r && wbWe && wbAdr == GDR_REG_CTRL && wbSel[0]) begin
      softOff_r <= wbDatW[GDR_CTRL_OFF_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      datR_r <= '0;
    end else if (wbReq && !wbWe) begin
      unique case (wbAdr)
        GDR_REG_CTRL: begin
          datR_r <= {31'h0, softOff_r};
        end
        GDR_REG_STAT: begin
          datR_r <= statWord;
        end
        default: begin
          datR_r <= '0;
        end
      endcase
    end
  end

  assign wbAck = ack_r;
  assign wbDatR = datR_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  noShootThru_a: assert property (@(posedge clock) disable iff (rst)
    (highGateOut & lowGateOut) == '0)
    else $error("high and low gate on together");

  highDecode_a: assert property (@(posedge clock) disable iff (rst)
    ($past(!hardGate) && $past(rearm_r) == '0) |-> highGateOut == $past(~highSideCmdN & lowSideCmdN))
    else $error("high gate does not follow its command");

  lowDecode_a: assert property (@(posedge clock) disable iff (rst)
    ($past(!hardGate) && $past(rearm_r) == '0) |-> lowGateOut == $past(~lowSideCmdN & highSideCmdN))
    else $error("low gate does not follow its command");

  hardOff_a: assert property (@(posedge clock) disable iff (rst)
    (flags_r.overV || flags_r.mainUv || flags_r.logicUv || flags_r.thermal) |=> (highGateOut | lowGateOut) == '0)
    else $error("gate on during hard protection");

  enableOff_a: assert property (@(posedge clock) disable iff (rst)
    !enFilt |=> ((highGateOut | lowGateOut) == '0) && rearm_r == '1)
    else $error("gate on while disabled");

  rearmHold_a: assert property (@(posedge clock) disable iff (rst)
    ((highGateOut | lowGateOut) & $past(rearm_r & ~fallEdge)) == '0)
    else $error("gate on before re-arming edge");

  rearmClear_a: assert property (@(posedge clock) disable iff (rst)
    (!hardGate && fallEdge[0]) |=> !rearm_r[0])
    else $error("falling edge did not clear re-arm");

  resetOff_a: assert property (@(posedge clock)
    (!rst && $past(rst)) |-> rearm_r == '1 && highGateOut == '0 && lowGateOut == '0)
    else $error("gates not off after reset");

  faultPin_a: assert property (@(posedge clock) disable iff (rst)
    (mainSupplyMv >= GDR_OVP_SET_MV) |-> ##2 faultOutNOe)
    else $error("fault pin not driven on overvoltage");

  faultNone_a: assert property (@(posedge clock) disable iff (rst)
    (!enFilt && flags_r == GDR_PROT_RST) |=> !faultOutNOe)
    else $error("fault pin driven while only disabled");

  gateUvRun_a: assert property (@(posedge clock) disable iff (rst)
    (flags_r.gateUv[0] && !hardGate && !rearm_r[0] && !highSideCmdN[0] && lowSideCmdN[0]) |=> highGateOut[0])
    else $error("gate stopped under gate-supply undervoltage");

  ovpHyst_a: assert property (@(posedge clock) disable iff (rst)
    (flags_r.overV && mainSupplyMv > GDR_OVP_CLR_MV) |=> flags_r.overV)
    else $error("overvoltage cleared above release level");

  pumpStop_a: assert property (@(posedge clock) disable iff (rst)
    (mainSupplyMv <= GDR_MUV_SET_MV) |-> ##2 !pumpBoostEn)
    else $error("pump boost running under main undervoltage");

  logicUv_a: assert property (@(posedge clock) disable iff (rst)
    (logicSupplyMv >= GDR_LUV_CLR_MV) |=> !flags_r.logicUv)
    else $error("logic undervoltage not released");

  gateUv_a: assert property (@(posedge clock) disable iff (rst)
    (gateDriveSupplyMv[0] <= GDR_GUV_SET_MV) |=> flags_r.gateUv[0])
    else $error("gate-supply undervoltage not set");

  wbAckPulse_a: assert property (@(posedge clock) disable iff (rst)
    wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");

endmodule

// ### gdr_pkg.sv
/*
  Shared constants and types for the three-phase gate drive logic:
  register map, status field layout, protection thresholds in millivolts
  and enable filter timing.
  Assumes a 200 MHz clock and supply measurements given in millivolts.
*/
package gdr_pkg;

  localparam int GDR_PHASES = 3;
  localparam int GDR_MV_W = 16;
  localparam int GDR_ADR_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int GDR_CLK_PERIOD_PS = 5000;
  localparam int GDR_EN_FILT_NS = 2500;
  // Least time, so round up
  localparam int GDR_EN_FILT_CYC = (GDR_EN_FILT_NS * 1000 + GDR_CLK_PERIOD_PS - 1) / GDR_CLK_PERIOD_PS;

  ////////////////////////////////////////////////////////////////////////////
  // Protection thresholds, millivolts
  localparam logic [15:0] GDR_OVP_SET_MV = 16'h6d60;
  localparam logic [15:0] GDR_OVP_CLR_MV = 16'h61a8;
  localparam logic [15:0] GDR_MUV_SET_MV = 16'h17d4;
  localparam logic [15:0] GDR_MUV_CLR_MV = 16'h1964;
  localparam logic [15:0] GDR_LUV_SET_MV = 16'h0ed8;
  localparam logic [15:0] GDR_LUV_CLR_MV = 16'h0fa0;
  localparam logic [15:0] GDR_GUV_SET_MV = 16'h1bbc;
  localparam logic [15:0] GDR_GUV_CLR_MV = 16'h1d4c;

  ////////////////////////////////////////////////////////////////////////////
  // Register map and fields
  localparam logic [7:0] GDR_REG_CTRL = 8'h00;
  localparam logic [7:0] GDR_REG_STAT = 8'h04;
  localparam int GDR_CTRL_OFF_BIT = 0;
  localparam logic GDR_CTRL_OFF_RST = 1'h0;
  localparam int GDR_ST_FLAGS_LSB = 0;
  localparam int GDR_ST_EN_BIT = 7;
  localparam int GDR_ST_PIN_BIT = 8;
  localparam int GDR_ST_REARM_LSB = 9;
  localparam int GDR_ST_HIGH_LSB = 12;
  localparam int GDR_ST_LOW_LSB = 15;

  typedef struct packed {
    logic thermal;
    logic [GDR_PHASES-1:0] gateUv;
    logic logicUv;
    logic mainUv;
    logic overV;
  } gdr_prot_t;

  localparam gdr_prot_t GDR_PROT_RST = '{default: 1'b0};

endpackage

// ### gdr_enable_filter.sv
/*
  Glitch filter for the enable input: the output takes a new level only
  after the raw input has held that level for CYCLES clocks.
  Assumes the raw input is already synchronous to clock.
*/
`timescale 1ns/1ps
module gdr_enable_filter
  import gdr_pkg::*;
#(
  parameter int CYCLES = GDR_EN_FILT_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic rawIn,
  output logic filtOut
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_r;
  logic filt_r;

  assign filtOut = filt_r;

  ////////////////////////////////////////////////////////////////////////////
  // A mismatch must last the full window; any return restarts the count
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (rawIn == filt_r || cnt_r == LAST) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      filt_r <= 1'b0;
    end else if (rawIn != filt_r && cnt_r == LAST) begin
      filt_r <= rawIn;
    end
  end

  filterWait_a: assert property (@(posedge clock) disable iff (rst)
    (filt_r != $past(filt_r)) |-> ($past(cnt_r) == LAST && $past(rawIn) == filt_r))
    else $error("enable filter changed before the window elapsed");

  filterReset_a: assert property (@(posedge clock)
    (!rst && $past(rst)) |-> !filt_r)
    else $error("enable filter not low after reset");

endmodule

// ### gdr_pwm_model.sv
/*
  PWM controller model for the gate drive bench: turns a requested code
  per phase into active-low high and low commands.
  Assumes the driver's clock and a bench that sets the codes.
*/
`timescale 1ns/1ps
module gdr_pwm_model
  import gdr_pkg::*;
#(
  parameter int HOLD = 100
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [GDR_PHASES-1:0][1:0] reqCode,
  output logic [GDR_PHASES-1:0] highSideCmdN,
  output logic [GDR_PHASES-1:0] lowSideCmdN,
  output logic [GDR_PHASES-1:0] settled
);
  // Codes: bit0 high side on, bit1 low side on; 3 is a deliberate overlap
  logic [GDR_PHASES-1:0][1:0] cur_r;
  logic [GDR_PHASES-1:0][7:0] hold_r;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    for (int p = 0; p < GDR_PHASES; p++) begin
      if (rst) begin
        cur_r[p] <= 2'h0;
        hold_r[p] <= 8'h00;
      end else if (hold_r[p] < 8'(HOLD)) begin
        hold_r[p] <= hold_r[p] + 8'h01;
      end else if (cur_r[p] != reqCode[p]) begin
        // Passing through idle for a full pulse width doubles as dead time
        cur_r[p] <= (cur_r[p] != 2'h0 && reqCode[p] != 2'h0) ? 2'h0 : reqCode[p];
        hold_r[p] <= 8'h00;
      end
    end
  end

  always_comb begin
    for (int p = 0; p < GDR_PHASES; p++) begin
      highSideCmdN[p] = !cur_r[p][0];
      lowSideCmdN[p] = !cur_r[p][1];
      settled[p] = cur_r[p] == reqCode[p];
    end
  end
endmodule

// ### three_phase_gate_drive_logic_test.sv
/*
  Self-checking bench for the gate drive logic: Wishbone register access,
  phase commands through the controller model, protections and enable.
  Assumes a 200 MHz clock and the model's 500 ns command hold.
*/
`timescale 1ns/1ps
module three_phase_gate_drive_logic_test
  import gdr_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatW = 32'h0;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatR;
  logic wbAck;
  logic enableIn = 1'b0;
  logic [15:0] mainSupplyMv = 16'h2ee0;
  logic [15:0] logicSupplyMv = 16'h1388;
  logic [GDR_PHASES-1:0][15:0] gateMv = {3{16'h2ee0}};
  logic thermalShutdown = 1'b0;
  logic [2:0] highSideCmdN, lowSideCmdN, highGateOut, lowGateOut, settled;
  logic [2:0][1:0] reqCode = '0;
  logic faultOutNOut, faultOutNOe, pumpBoostEn, faultLine;
  logic [31:0] rd;
  logic [15:0] setV[5], nearV[5], clrV[5], midV;
  int bitK[5] = '{0, 1, 2, 6, 4};
  int errors = 0;
  int testsRun = 0;

  always #2.5 clock = ~clock;
  // Open drain with external pull-up
  assign faultLine = faultOutNOe ? faultOutNOut : 1'b1;

  gdr_gate_logic #(.EN_FILT_CYC(8)) u_gdr_gate_logic (.clock(clock), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbDatW(wbDatW), .wbSel(wbSel), .wbDatR(wbDatR), .wbAck(wbAck),
    .highSideCmdN(highSideCmdN), .lowSideCmdN(lowSideCmdN), .enableIn(enableIn), .mainSupplyMv(mainSupplyMv),
    .logicSupplyMv(logicSupplyMv), .gateDriveSupplyMv(gateMv), .thermalShutdown(thermalShutdown),
    .highGateOut(highGateOut), .lowGateOut(lowGateOut), .faultOutNIn(faultLine), .faultOutNOut(faultOutNOut),
    .faultOutNOe(faultOutNOe), .pumpBoostEn(pumpBoostEn));
  gdr_pwm_model #(.HOLD(100)) u_gdr_pwm_model (.clock(clock), .rst(rst), .reqCode(reqCode),
    .highSideCmdN(highSideCmdN), .lowSideCmdN(lowSideCmdN), .settled(settled));

  ////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("comparisons %0d mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic cycle; ack is seen settled before the edge that samples it, data taken and request dropped at that edge
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatW <= dat;
    wbSel <= 4'hf;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (wbAck !== 1'b1) begin
      errors++;
      give_verdict;
    end
    @(posedge clock);
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task set_ph(input logic [2:0] mask, input logic [1:0] code);
    int n;
    @(posedge clock);
    for (int p = 0; p < 3; p++) if (mask[p]) reqCode[p] <= code;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while ((settled & mask) !== mask && n < 1000);
    if ((settled & mask) !== mask) begin
      errors++;
      give_verdict;
    end
    repeat (3) @(negedge clock);
  endtask

  task sup(input int k, input logic [15:0] v);
    @(posedge clock);
    if (k < 2) mainSupplyMv <= v;
    else if (k == 2) logicSupplyMv <= v;
    else if (k == 3) thermalShutdown <= v[0];
    else gateMv <= {3{v}};
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask

  task en_pulse(input logic lvl, input int cyc);
    @(posedge clock);
    if (cyc > 0) begin
      enableIn <= lvl;
      repeat (cyc) @(posedge clock);
    end
    enableIn <= !lvl;
    repeat (12) @(posedge clock);
    @(negedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    setV = '{GDR_OVP_SET_MV, GDR_MUV_SET_MV, GDR_LUV_SET_MV, 16'h0001, GDR_GUV_SET_MV};
    nearV = '{GDR_OVP_SET_MV - 16'h1, GDR_MUV_SET_MV + 16'h1, GDR_LUV_SET_MV + 16'h1, 16'h0, GDR_GUV_SET_MV + 16'h1};
    clrV = '{GDR_OVP_CLR_MV, GDR_MUV_CLR_MV, GDR_LUV_CLR_MV, 16'h0000, GDR_GUV_CLR_MV};
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check({highGateOut, lowGateOut}, 6'h00);
    wb(1'b0, GDR_REG_STAT, 32'h0);
    check(rd, 32'h00000f00);
    en_pulse(1'b1, 5);
    wb(1'b0, GDR_REG_STAT, 32'h0);
    check(rd[GDR_ST_EN_BIT], 1'b0);
    en_pulse(1'b0, 0);
    wb(1'b0, GDR_REG_STAT, 32'h0);
    check(rd[GDR_ST_EN_BIT], 1'b1);
    set_ph(3'h7, 2'h1);
    check({highGateOut, lowGateOut}, 6'h38);
    set_ph(3'h4, 2'h3);
    check({highGateOut, lowGateOut}, 6'h18);
    set_ph(3'h4, 2'h2);
    check({highGateOut, lowGateOut}, 6'h1c);
    set_ph(3'h4, 2'h1);
    check(pumpBoostEn, 1'b1);
    for (int k = 0; k < 5; k++) begin
      midV = (k == 3) ? 16'h0001 : (setV[k] + clrV[k]) >> 1;
      sup(k, nearV[k]);
      check(faultLine, 1'b1);
      sup(k, setV[k]);
      check(faultLine, 1'b0);
      check(highGateOut, (k == 4) ? 3'h7 : 3'h0);
      check(pumpBoostEn, k != 1);
      wb(1'b0, GDR_REG_STAT, 32'h0);
      check(rd[bitK[k]], 1'b1);
      sup(k, midV);
      check(faultOutNOe, 1'b1);
      sup(k, clrV[k]);
      check(faultLine, 1'b1);
      check(highGateOut, (k == 4) ? 3'h7 : 3'h0);
      check(pumpBoostEn, 1'b1);
      set_ph(3'h1, 2'h0);
      set_ph(3'h1, 2'h1);
      check(highGateOut, (k == 4) ? 3'h7 : 3'h1);
      set_ph(3'h6, 2'h0);
      set_ph(3'h6, 2'h1);
      check(highGateOut, 3'h7);
    end
    en_pulse(1'b0, 5);
    check(highGateOut, 3'h7);
    @(posedge clock);
    enableIn <= 1'b0;
    repeat (12) @(posedge clock);
    @(negedge clock);
    check({highGateOut, lowGateOut}, 6'h00);
    check(faultLine, 1'b1);
    en_pulse(1'b1, 12);
    en_pulse(1'b0, 0);
    check(highGateOut, 3'h0);
    set_ph(3'h7, 2'h0);
    set_ph(3'h7, 2'h1);
    check(highGateOut, 3'h7);
    wb(1'b1, GDR_REG_CTRL, 32'h1);
    repeat (4) @(negedge clock);
    check(highGateOut, 3'h0);
    check(faultLine, 1'b1);
    wb(1'b0, GDR_REG_CTRL, 32'h0);
    check(rd, 32'h1);
    wb(1'b1, GDR_REG_CTRL, 32'h0);
    wb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    give_verdict;
  end
endmodule
